//--- net_diag_flags.sv
// diagnostic flag register bank with classic wishbone slave
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
module net_diag_flags
   import net_diag_pkg::*;
(
   input  wire logic        clk_i,              // system clock
   input  wire logic        rst_i,              // synchronous reset
   input  wire wb_req_type  wb_i,               // wishbone request
   output logic             wb_ack_o,           // wishbone acknowledge
   output logic [31:0]      wb_dat_o,           // wishbone read data
   output logic             irq_o,              // interrupt level
   input  wire logic        serial_receive_input_i, // receive pin
   input  wire logic        lost_token_expired_i,   // timer pulse
   input  wire token_type   token_i,            // token events
   input  wire logic        nak_received_i,     // enquiry nak pulse
   input  wire logic        next_id_update_i,   // next id strobe
   input  wire logic [7:0]  next_id_i,          // new next id
   output logic             tx_enable_o,        // transmitter enabled
   output logic [7:0]       node_id_o           // node identity
);

   typedef struct packed {
      logic [7:0]  flags;
      logic [7:0]  irq_status;
      logic [7:0]  irq_mask;
      logic [2:0]  control;
      logic [7:0]  node_id;
      logic [7:0]  tent_id;
      logic [7:0]  next_id;
      logic [7:0]  nak_count;
      logic        ack;
      logic [31:0] dat;
      logic        irq;
   } bank_state_type;

   bank_state_type state;
   bank_state_type next_state;

   logic       rx_level;
   logic       access;
   logic       rd;
   logic       wr;
   logic [7:0] wdat;
   logic [7:0] set_ev;
   logic [7:0] clr_ev;
   logic [7:0] nak_limit;
   logic       clear_cmd;
   logic       dup_match;
   logic       dup_online;

   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] offset);
      hit = (adr[7:2] == offset[7:2]);
   endfunction : hit

   function automatic logic [31:0] widen(input logic [7:0] v);
      widen = {24'h00_0000, v};
   endfunction : widen

   rx_line_sync rx_line_sync_inst (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .line_i  (serial_receive_input_i),
      .level_o (rx_level)
   );

   // one access per request, ack dropped the cycle after
   assign access = wb_i.cyc && wb_i.stb && !state.ack;
   assign rd     = access && !wb_i.we;
   assign wr     = access && wb_i.we && wb_i.sel[0];
   assign wdat   = wb_i.dat[7:0];

   assign clear_cmd = wr && hit(wb_i.adr, COMMAND_OFFSET)
                      && wdat[CMD_CLEAR_FLAGS];

   assign nak_limit = state.control[CTRL_NAK_SHORT]
                      ? NAK_LIMIT_SHORT : NAK_LIMIT_LONG;

   assign dup_match = token_i.answered
                      && token_i.first_id == state.node_id
                      && token_i.second_id == state.node_id
                      && token_i.zeros_ok;
   assign dup_online = token_i.got_token
                       && state.control[CTRL_TX_ENABLE]
                       && state.control[CTRL_ON_LINE];

   // flag set events
   always_comb begin
      set_ev = 8'h00;
      set_ev[BIT_SELF_RECONFIG] = lost_token_expired_i;
      set_ev[BIT_DUPLICATE_ID]  = dup_match || dup_online;
      set_ev[BIT_RX_ACTIVITY]   = rx_level;
      set_ev[BIT_TOKEN_SEEN]    = token_i.seen
                                  && !token_i.from_self;
      set_ev[BIT_EXCESSIVE_NAK] = nak_received_i
                                  && state.nak_count
                                     == nak_limit - 8'h01;
      set_ev[BIT_TENTATIVE_HIT] = token_i.answered
                                  && token_i.first_id
                                     == state.tent_id;
      set_ev[BIT_NEXT_CHANGED]  = next_id_update_i;
   end

   // flag clear events; sets override them below
   always_comb begin
      clr_ev = 8'h00;
      if (clear_cmd) begin
         clr_ev = CMD_CLEAR_BITS;
      end
      if (rd && hit(wb_i.adr, FLAGS_OFFSET)) begin
         clr_ev[BIT_DUPLICATE_ID] = 1'b1;
      end
      if (rd && hit(wb_i.adr, NEXT_ID_OFFSET)) begin
         clr_ev[BIT_NEXT_CHANGED] = 1'b1;
      end
   end

   always_comb begin
      next_state = state;
      next_state.ack = access;
      next_state.dat = DATA_RESET;

      // set wins over clear
      next_state.flags = (state.flags & ~clr_ev) | set_ev;
      next_state.flags[BIT_UNDEFINED] = 1'b0;

      if (clear_cmd) begin
         next_state.nak_count = COUNT_RESET;
      end else if (nak_received_i && state.nak_count != nak_limit) begin
         next_state.nak_count = state.nak_count + 8'h01;
      end

      if (next_id_update_i) begin
         next_state.next_id = next_id_i;
      end

      // register writes
      if (wr) begin
         if (hit(wb_i.adr, IRQ_MASK_OFFSET)) begin
            next_state.irq_mask = wdat;
         end
         if (hit(wb_i.adr, CONTROL_OFFSET)) begin
            next_state.control = wdat[2:0];
         end
         if (hit(wb_i.adr, NODE_ID_OFFSET)) begin
            next_state.node_id = wdat;
         end
         if (hit(wb_i.adr, TENT_ID_OFFSET)) begin
            next_state.tent_id = wdat;
         end
      end

      // sticky event status, write one to clear, set wins
      next_state.irq_status = state.irq_status;
      if (wr && hit(wb_i.adr, IRQ_STATUS_OFFSET)) begin
         next_state.irq_status = state.irq_status & ~wdat;
      end
      next_state.irq_status = next_state.irq_status | set_ev;

      // read data, sampled before this cycle's side effects
      if (rd) begin
         unique case (1'b1)
            hit(wb_i.adr, FLAGS_OFFSET): begin
               next_state.dat = widen(state.flags);
            end
            hit(wb_i.adr, IRQ_STATUS_OFFSET): begin
               next_state.dat = widen(state.irq_status);
            end
            hit(wb_i.adr, IRQ_MASK_OFFSET): begin
               next_state.dat = widen(state.irq_mask);
            end
            hit(wb_i.adr, CONTROL_OFFSET): begin
               next_state.dat = widen({5'h00, state.control});
            end
            hit(wb_i.adr, NODE_ID_OFFSET): begin
               next_state.dat = widen(state.node_id);
            end
            hit(wb_i.adr, TENT_ID_OFFSET): begin
               next_state.dat = widen(state.tent_id);
            end
            hit(wb_i.adr, NEXT_ID_OFFSET): begin
               next_state.dat = widen(state.next_id);
            end
            default: begin
               next_state.dat = DATA_RESET;
            end
         endcase
      end

      // level flags hold the line while set and unmasked
      next_state.irq = |((next_state.irq_status
                          | (next_state.flags & LEVEL_IRQ_BITS))
                         & next_state.irq_mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state.flags      <= FLAGS_RESET;
         state.irq_status <= FLAGS_RESET;
         state.irq_mask   <= MASK_RESET;
         state.control    <= CONTROL_RESET;
         state.node_id    <= ID_RESET;
         state.tent_id    <= ID_RESET;
         state.next_id    <= ID_RESET;
         state.nak_count  <= COUNT_RESET;
         state.ack        <= 1'b0;
         state.dat        <= DATA_RESET;
         state.irq        <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign wb_ack_o    = state.ack;
   assign wb_dat_o    = state.dat;
   assign irq_o       = state.irq;
   assign tx_enable_o = state.control[CTRL_TX_ENABLE];
   assign node_id_o   = state.node_id;

   // checks

   self_reconfig_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      lost_token_expired_i |=> state.flags[BIT_SELF_RECONFIG])
      else $error("reconfig flag not set after timer expiry");

   dup_match_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      token_i.answered && token_i.zeros_ok
      && token_i.first_id == state.node_id
      && token_i.second_id == state.node_id
      |=> state.flags[BIT_DUPLICATE_ID])
      else $error("duplicate id flag missed on matching token");

   dup_online_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      token_i.got_token && tx_enable_o && state.control[CTRL_ON_LINE]
      |=> state.flags[BIT_DUPLICATE_ID])
      else $error("duplicate id flag not set on line");

   dup_read_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_i.cyc && wb_i.stb && !wb_i.we && !wb_ack_o
      && wb_i.adr[7:2] == FLAGS_OFFSET[7:2]
      && !token_i.answered && !token_i.got_token
      |=> !state.flags[BIT_DUPLICATE_ID])
      else $error("duplicate id flag survived a read");

   rx_activity_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_level |=> state.flags[BIT_RX_ACTIVITY])
      else $error("receive activity not flagged");

   token_seen_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      token_i.seen && !token_i.from_self
      |=> state.flags[BIT_TOKEN_SEEN])
      else $error("foreign token not flagged");

   nak_limit_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      nak_received_i && !clear_cmd
      && state.nak_count == nak_limit - 8'h01
      |=> state.flags[BIT_EXCESSIVE_NAK])
      else $error("nak limit reached but flag clear");

   nak_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state.flags[BIT_EXCESSIVE_NAK] && !clear_cmd
      |=> state.flags[BIT_EXCESSIVE_NAK])
      else $error("nak flag cleared without command");

   nak_irq_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state.flags[BIT_EXCESSIVE_NAK] && state.irq_mask[BIT_EXCESSIVE_NAK]
      |-> irq_o)
      else $error("nak flag unmasked but no interrupt");

   tent_hit_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      token_i.answered && token_i.first_id == state.tent_id
      |=> state.flags[BIT_TENTATIVE_HIT])
      else $error("tentative id hit not flagged");

   next_changed_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      next_id_update_i |=> state.flags[BIT_NEXT_CHANGED]
      && state.next_id == $past(next_id_i))
      else $error("next id update not captured");

   next_irq_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state.flags[BIT_NEXT_CHANGED] && state.irq_mask[BIT_NEXT_CHANGED]
      |-> irq_o)
      else $error("next id flag unmasked but no interrupt");

   undefined_bit_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !state.flags[BIT_UNDEFINED])
      else $error("undefined flag bit became set");

   dup_keep_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rd && hit(wb_i.adr, FLAGS_OFFSET) && dup_match
      |=> state.flags[BIT_DUPLICATE_ID])
      else $error("duplicate id event lost on read");

   ack_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   ack_answer_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      access |=> wb_ack_o)
      else $error("request taken but not acknowledged");

   dat_idle_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == DATA_RESET)
      else $error("read data not zero outside ack");

   next_read_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rd && hit(wb_i.adr, NEXT_ID_OFFSET) && !next_id_update_i
      |=> !state.flags[BIT_NEXT_CHANGED])
      else $error("next changed flag survived next id read");

   next_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state.flags[BIT_NEXT_CHANGED] && !(rd && hit(wb_i.adr, NEXT_ID_OFFSET))
      |=> state.flags[BIT_NEXT_CHANGED])
      else $error("next changed flag cleared without next id read");

   nak_cmd_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      clear_cmd && !nak_received_i
      |=> !state.flags[BIT_EXCESSIVE_NAK] && state.nak_count == COUNT_RESET)
      else $error("clear command left nak state behind");

   status_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr && hit(wb_i.adr, IRQ_STATUS_OFFSET) && wdat[BIT_SELF_RECONFIG]
      && !lost_token_expired_i
      |=> !state.irq_status[BIT_SELF_RECONFIG])
      else $error("status bit not cleared by writing one");

endmodule : net_diag_flags

//--- net_diag_pkg.sv
// constants and carrier types for the network diagnostic flag register bank
// Summary of operation
// - lost-token timer expiry sets bit 7, this node caused the reconfiguration.
// - bit 6 sets when both token ids match node id, zeros ok, answered.
// - with transmitter enabled and on line, every token received sets bit 6.
// - any host read of the flag register clears bit 6; here a bit 6 event in the same cycle keeps it set.
// - a logic one level on the serial receive input sets bit 5.
// - bit 4 sets when a token sent by another node is seen.
// - bit 3 sets after 128 or 4 negative acknowledgements, as configured.
// - interrupt stays high while bit 3 and its mask bit are set.
// - bit 2 sets on an answered token whose first id equals tentative id.
// - next-node id update sets bit 1; next-id register read clears it.
// - interrupt stays high while bit 1 and its mask bit are set.
// - lowest bit is undefined; software must not rely on it.
package net_diag_pkg;

   // register byte offsets
   localparam logic [7:0] FLAGS_OFFSET      = 8'h00;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
   localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h08;
   localparam logic [7:0] CONTROL_OFFSET    = 8'h0C;
   localparam logic [7:0] COMMAND_OFFSET    = 8'h10;
   localparam logic [7:0] NODE_ID_OFFSET    = 8'h14;
   localparam logic [7:0] TENT_ID_OFFSET    = 8'h18;
   localparam logic [7:0] NEXT_ID_OFFSET    = 8'h1C;

   // flag bit positions
   localparam int BIT_SELF_RECONFIG  = 7;
   localparam int BIT_DUPLICATE_ID   = 6;
   localparam int BIT_RX_ACTIVITY    = 5;
   localparam int BIT_TOKEN_SEEN     = 4;
   localparam int BIT_EXCESSIVE_NAK  = 3;
   localparam int BIT_TENTATIVE_HIT  = 2;
   localparam int BIT_NEXT_CHANGED   = 1;
   localparam int BIT_UNDEFINED      = 0;

   // control and command bit positions
   localparam int CTRL_TX_ENABLE     = 0;
   localparam int CTRL_ON_LINE       = 1;
   localparam int CTRL_NAK_SHORT     = 2;
   localparam int CMD_CLEAR_FLAGS    = 0;

   // reset values
   localparam logic [7:0]  FLAGS_RESET   = 8'h00;
   localparam logic [7:0]  MASK_RESET    = 8'h00;
   localparam logic [2:0]  CONTROL_RESET = 3'h0;
   localparam logic [7:0]  ID_RESET      = 8'h00;
   localparam logic [7:0]  COUNT_RESET   = 8'h00;
   localparam logic [31:0] DATA_RESET    = 32'h0000_0000;

   // flags that hold the interrupt as a level
   localparam logic [7:0] LEVEL_IRQ_BITS = 8'h0A;
   // flags that the clear-flags command clears
   localparam logic [7:0] CMD_CLEAR_BITS = 8'hBC;

   // negative acknowledgement limits
   localparam logic [7:0] NAK_LIMIT_LONG  = 8'h80;
   localparam logic [7:0] NAK_LIMIT_SHORT = 8'h04;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic       seen;       // token observed on the network
      logic       from_self;  // observed token was sent by this node
      logic       answered;   // some node responded to the token
      logic       got_token;  // this node received the token
      logic [7:0] first_id;   // first destination identity
      logic [7:0] second_id;  // second destination identity
      logic       zeros_ok;   // trailing zeros checked correctly
   } token_type;

endpackage : net_diag_pkg

//--- net_host_model.sv
// wishbone host model that issues single classic cycles to the flag bank
`timescale 1ns/100ps
module net_host_model
   import net_diag_pkg::*;
(
   input  wire logic        clk_i,  // system clock
   output wb_req_type       wb_o,   // request to the register bank
   input  wire logic        ack_i,  // acknowledge from the bank
   input  wire logic [31:0] dat_i   // read data from the bank
);
   initial wb_o = '0;

   // request held until ack is sampled high; released only at that edge
   task xfer(input logic we, input logic [7:0] adr, input logic [7:0] wdat,
             output logic [31:0] rdat);
      @(posedge clk_i);
      wb_o <= {1'b1, 1'b1, we, adr, 4'h1, 24'h00_0000, wdat};
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      rdat = dat_i;
      wb_o <= '0;
   endtask : xfer
endmodule : net_host_model

//--- rx_line_sync.sv
// two-stage synchroniser for the serial receive input pin
`timescale 1ns/100ps
module rx_line_sync
   import net_diag_pkg::*;
(
   input  wire logic clk_i,   // system clock
   input  wire logic rst_i,   // synchronous reset, active high
   input  wire logic line_i,  // asynchronous receive pin
   output logic      level_o  // synchronised level
);

   typedef struct packed {
      logic first;
      logic second;
   } sync_state_type;

   sync_state_type state;
   sync_state_type next_state;

   always_comb begin
      next_state.first  = line_i;
      next_state.second = state.first;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign level_o = state.second;

endmodule : rx_line_sync

//--- test_network_diagnostic_flags.sv
// self-checking testbench for the diagnostic flag register bank
`timescale 1ns/100ps
module test_network_diagnostic_flags;
   import net_diag_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   wb_req_type  wb;
   logic        ack;
   logic [31:0] dat;
   logic        irq_o;
   logic        serial_receive_input_i = 1'b0;
   logic        lost_token_expired_i = 1'b0;
   token_type   token_i = '0;
   logic        nak_received_i = 1'b0;
   logic        next_id_update_i = 1'b0;
   logic [7:0]  next_id_i = 8'h00;
   logic        tx_enable_o;
   logic [7:0]  node_id_o;
   int          n_fail = 0;
   int          n_tests = 0;
   int          cycles = 0;
   logic [31:0] v;

   always #10 clk_i = ~clk_i;

   net_host_model host_inst (.clk_i(clk_i), .wb_o(wb), .ack_i(ack), .dat_i(dat));

   net_diag_flags net_diag_flags_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(ack), .wb_dat_o(dat),
      .irq_o(irq_o), .serial_receive_input_i(serial_receive_input_i),
      .lost_token_expired_i(lost_token_expired_i), .token_i(token_i),
      .nak_received_i(nak_received_i), .next_id_update_i(next_id_update_i),
      .next_id_i(next_id_i), .tx_enable_o(tx_enable_o), .node_id_o(node_id_o));

   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_fail++;
         conclude();
      end
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      host_inst.xfer(1'b1, a, d, x);
   endtask : wr

   task rc(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      host_inst.xfer(1'b0, a, 8'h00, x);
      check(n, x, e);
   endtask : rc

   // flag read; the lowest bit is not compared
   task rf(input string n, input logic [31:0] e);
      logic [31:0] x;
      host_inst.xfer(1'b0, FLAGS_OFFSET, 8'h00, x);
      check(n, {x[31:1], 1'b0}, e);
   endtask : rf

   task ci(input logic e);
      @(negedge clk_i);
      check("irq", {31'h0000_0000, irq_o}, {31'h0000_0000, e});
   endtask : ci

   function automatic token_type mk(logic s, logic f, logic a, logic g,
                                    logic [7:0] i1, logic [7:0] i2, logic z);
      mk = {s, f, a, g, i1, i2, z};
   endfunction : mk

   task tok(input token_type t);
      @(posedge clk_i);
      token_i <= t;
      @(posedge clk_i);
      token_i <= '0;
   endtask : tok

   task naks(input int n);
      repeat (n) @(posedge clk_i) nak_received_i <= 1'b1;
      @(posedge clk_i);
      nak_received_i <= 1'b0;
   endtask : naks

   task clear_cmd;
      wr(COMMAND_OFFSET, 8'h01);
   endtask : clear_cmd

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rf("flags after reset", 32'h0000_0000);
      rc("mask after reset", IRQ_MASK_OFFSET, 32'h0000_0000);
      rc("unmapped read", 8'hFC, 32'h0000_0000);
      ci(1'b0);
      // timer expiry
      @(posedge clk_i) lost_token_expired_i <= 1'b1;
      @(posedge clk_i) lost_token_expired_i <= 1'b0;
      rf("self reconfig", 32'h0000_0080);
      clear_cmd();
      rf("flags cleared", 32'h0000_0000);
      // line activity through the synchroniser
      @(posedge clk_i) serial_receive_input_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      serial_receive_input_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rf("rx activity", 32'h0000_0020);
      clear_cmd();
      tok(mk(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0));
      rf("own token", 32'h0000_0000);
      tok(mk(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0));
      rf("foreign token", 32'h0000_0010);
      clear_cmd();
      // duplicate identity, off line
      wr(NODE_ID_OFFSET, 8'h35);
      check("node id out", {24'h00_0000, node_id_o}, 32'h0000_0035);
      rc("node id", NODE_ID_OFFSET, 32'h0000_0035);
      tok(mk(1'b0, 1'b0, 1'b1, 1'b0, 8'h35, 8'h35, 1'b0));
      rf("dup bad zeros", 32'h0000_0000);
      tok(mk(1'b0, 1'b0, 1'b1, 1'b0, 8'h35, 8'h34, 1'b1));
      rf("dup one id", 32'h0000_0000);
      tok(mk(1'b0, 1'b0, 1'b1, 1'b0, 8'h35, 8'h35, 1'b1));
      rf("dup set", 32'h0000_0040);
      rf("dup read clear", 32'h0000_0000);
      // event in the cycle the read is taken
      fork
         host_inst.xfer(1'b0, FLAGS_OFFSET, 8'h00, v);
         tok(mk(1'b0, 1'b0, 1'b1, 1'b0, 8'h35, 8'h35, 1'b1));
      join
      check("read beside event", v, 32'h0000_0000);
      rf("dup survives read", 32'h0000_0040);
      // on line every received token sets the duplicate flag
      wr(CONTROL_OFFSET, 8'h03);
      check("tx enable out", {31'h0000_0000, tx_enable_o}, 32'h0000_0001);
      tok(mk(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 1'b0));
      rf("dup on line", 32'h0000_0040);
      wr(CONTROL_OFFSET, 8'h00);
      tok(mk(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 1'b0));
      rf("dup off line", 32'h0000_0000);
      // tentative identity ignores second id and zeros
      wr(TENT_ID_OFFSET, 8'h22);
      tok(mk(1'b0, 1'b0, 1'b1, 1'b0, 8'h22, 8'h99, 1'b0));
      rf("tentative hit", 32'h0000_0004);
      clear_cmd();
      // short nak limit with interrupt
      wr(IRQ_MASK_OFFSET, 8'h08);
      wr(CONTROL_OFFSET, 8'h04);
      rc("control", CONTROL_OFFSET, 32'h0000_0004);
      naks(3);
      rf("nak below 4", 32'h0000_0000);
      ci(1'b0);
      naks(1);
      rf("nak at 4", 32'h0000_0008);
      ci(1'b1);
      rc("status sticky", IRQ_STATUS_OFFSET, 32'h0000_00FC);
      rf("nak kept by read", 32'h0000_0008);
      clear_cmd();
      rf("nak cleared", 32'h0000_0000);
      wr(IRQ_STATUS_OFFSET, 8'hFF);
      ci(1'b0);
      rc("status cleared", IRQ_STATUS_OFFSET, 32'h0000_0000);
      // long nak limit
      wr(CONTROL_OFFSET, 8'h00);
      naks(127);
      rf("nak below 128", 32'h0000_0000);
      naks(1);
      rf("nak at 128", 32'h0000_0008);
      clear_cmd();
      wr(IRQ_STATUS_OFFSET, 8'hFF);
      // next node change
      wr(IRQ_MASK_OFFSET, 8'h02);
      @(posedge clk_i) begin
         next_id_update_i <= 1'b1;
         next_id_i        <= 8'h5A;
      end
      @(posedge clk_i) next_id_update_i <= 1'b0;
      rf("next changed", 32'h0000_0002);
      rf("next kept by read", 32'h0000_0002);
      ci(1'b1);
      rc("next id", NEXT_ID_OFFSET, 32'h0000_005A);
      rf("next cleared", 32'h0000_0000);
      wr(IRQ_STATUS_OFFSET, 8'hFF);
      ci(1'b0);
      conclude();
   end
endmodule : test_network_diagnostic_flags
